/* File: diag_far_model.sv */
// far side: general registers, self-test engines, lookaside buffer, saved state
`timescale 1ns/1ps
module diag_far_model (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic slow,
  input wire logic [4:0] gpr_rd_idx,
  output logic [31:0] gpr_rd_data,
  input wire logic icache_selftest_start,
  output logic icache_selftest_done,
  input wire logic dcache_selftest_start,
  output logic dcache_selftest_done,
  input wire logic lab_rd_req,
  output logic lab_rd_ack,
  output logic [31:0] lab_rd_vpn,
  output logic [31:0] lab_rd_rpn,
  output diag_unit_pkg::ret_state_s saved_state
);
  logic [5:0] ic_cnt_r;
  logic [5:0] dc_cnt_r;
  logic [1:0] lab_cnt_r;
  ////////////////////////////////////////
  // each register reads as a pattern carrying its own index
  assign gpr_rd_data = {24'ha53c96, 3'h0, gpr_rd_idx};
  assign saved_state = '{32'h0f0f, 32'h1004, 32'h1008, 32'h0033, 32'h0044};
  assign icache_selftest_done = ic_cnt_r == 6'h01;
  assign dcache_selftest_done = dc_cnt_r == 6'h01;
  // inverted outside the ack cycle so stale data never matches
  assign lab_rd_vpn = lab_rd_ack ? 32'h1234 : 32'hffff_edcb;
  assign lab_rd_rpn = lab_rd_ack ? 32'h5678 : 32'hffff_a987;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ic_cnt_r <= 6'h00;
      dc_cnt_r <= 6'h00;
      lab_cnt_r <= 2'h0;
      lab_rd_ack <= 1'b0;
    end else begin
      ic_cnt_r <= icache_selftest_start ? 6'h05 : ic_cnt_r - 6'(ic_cnt_r != 6'h00);
      dc_cnt_r <= dcache_selftest_start ? (slow ? 6'h1e : 6'h05)
        : dc_cnt_r - 6'(dc_cnt_r != 6'h00);
      lab_cnt_r <= (lab_rd_req && !lab_rd_ack) ? lab_cnt_r + 2'h1 : 2'h0;
      lab_rd_ack <= lab_rd_req && !lab_rd_ack && lab_cnt_r == 2'h2;
    end
  end
endmodule : diag_far_model

/* File: diag_insn_unit.sv */
// diagnose instruction decoder and executor with wishbone status port
//
// Decided for this implementation: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`include "diag_unit_map.svh"
module diag_insn_unit (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire diag_unit_pkg::insn_s insn,
  output logic insn_busy,
  input wire logic sync_valid,
  output logic sync_stall,
  output logic priv_trap,
  output logic illegal_insn,
  output diag_unit_pkg::gpr_wr_s gpr_wr,
  output logic [4:0] gpr_rd_idx,
  input wire logic [31:0] gpr_rd_data,
  output logic icache_selftest_start,
  input wire logic icache_selftest_done,
  output logic dcache_selftest_start,
  input wire logic dcache_selftest_done,
  output logic lab_rd_req,
  input wire logic lab_rd_ack,
  input wire logic [31:0] lab_rd_vpn,
  input wire logic [31:0] lab_rd_rpn,
  output logic lab_wr_req,
  output logic [31:0] lab_wr_vpn,
  output logic [31:0] lab_wr_rpn,
  input wire logic toc_request,
  output logic transfer_of_control_trap,
  input wire diag_unit_pkg::ret_state_s saved_state,
  output diag_unit_pkg::ret_state_s restored_state,
  output logic restore_valid,
  input wire logic [7:0] machine_check_error_bits,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o
);
  ////////////////////////////////////////////////////////////////////////////
  // decode
  // format bit 0 is word bit 31, so the extension sits at word[12:5]
  logic [5:0] major;
  logic [7:0] ext;
  logic [7:0] ext_m;
  logic is_diag;
  logic privileged_ok;
  logic [4:0] fld_r;
  logic [4:0] fld_x;
  logic [4:0] fld_t;
  assign major = insn.word[31:26];
  assign ext = insn.word[12:5];
  assign ext_m = ext & `DIAG_EXT_MASK;
  assign fld_r = insn.word[25:21];
  assign fld_x = insn.word[20:16];
  assign fld_t = insn.word[4:0];
  assign is_diag = insn.valid && (major == `DIAG_MAJOR_OP) && !insn_busy;
  assign privileged_ok = (insn.priv == 2'h0);
  logic go;
  assign go = is_diag && privileged_ok;
  logic d_mt, d_mfa, d_mfb, d_ic, d_dc, d_lr, d_lw, d_ten, d_tdis, d_s2g, d_g2s, d_ret;
  logic d_b0, d_b1;
  always_comb begin
    d_mt = go && (ext_m == `EXT_MOVE_TO);
    d_mfa = go && (ext_m == `EXT_MOVE_FROM_A);
    d_mfb = go && (ext_m == `EXT_MOVE_FROM_B);
    d_ic = go && (ext_m == `EXT_ICACHE_TEST);
    d_dc = go && (ext_m == `EXT_DCACHE_TEST);
    d_lr = go && (ext_m == `EXT_LAB_READ);
    d_lw = go && (ext_m == `EXT_LAB_WRITE);
    d_ten = go && (ext_m == `EXT_TRAP_UNMASK);
    d_tdis = go && (ext_m == `EXT_TRAP_MASK);
    d_s2g = go && (ext_m == `EXT_SHADOW_TO_GPR);
    d_g2s = go && (ext_m == `EXT_GPR_TO_SHADOW);
    d_ret = go && ((ext & `EXT_IMPL_RET_MASK) == `EXT_IMPL_RETURN);
    d_b0 = go && (ext_m == `EXT_BANK_ZERO);
    d_b1 = go && (ext_m == `EXT_BANK_ONE);
  end
  logic any_known;
  assign any_known = d_mt | d_mfa | d_mfb | d_ic | d_dc | d_lr | d_lw | d_ten | d_tdis
    | d_s2g | d_g2s | d_ret | d_b0 | d_b1;
  // mis-pathed move-from is refused rather than answered with the wrong port
  logic mf_bad;
  assign mf_bad = (d_mfa && (fld_r == `DR_ERR_REG || fld_r == `DR_CH_REG))
    || (d_mfb && !(fld_r == `DR_ERR_REG || fld_r == `DR_CH_REG));
  ////////////////////////////////////////////////////////////////////////////
  // flags, self-test tracking, shadow sequencer
  logic diag_bank_bit_r, diag_bank_bit_nxt;
  logic soft_trap_enable_flag_r, soft_trap_enable_flag_nxt;
  logic toc_pend_r, toc_pend_nxt;
  logic ic_run_r, ic_run_nxt, dc_run_r, dc_run_nxt;
  logic lab_rd_r, lab_rd_nxt;
  diag_unit_pkg::seq_e seq_r, seq_nxt;
  logic dir_r, dir_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [31:0] shadow_reg_array_r [7];
  logic [31:0] shadow_nxt [7];
  logic [4:0] map_idx [7];
  assign map_idx = '{5'h01, 5'h08, 5'h09, 5'h10, 5'h11, 5'h18, 5'h19};
  always_comb begin
    diag_bank_bit_nxt = diag_bank_bit_r;
    if (d_b0) diag_bank_bit_nxt = 1'b0;
    if (d_b1) diag_bank_bit_nxt = 1'b1;
    soft_trap_enable_flag_nxt = soft_trap_enable_flag_r;
    if (d_ten) soft_trap_enable_flag_nxt = 1'b1;
    if (d_tdis) soft_trap_enable_flag_nxt = 1'b0;
    // condition collected even while masked; taking it consumes it
    toc_pend_nxt = (toc_pend_r && !transfer_of_control_trap) || toc_request;
    ic_run_nxt = (ic_run_r && !icache_selftest_done) || d_ic;
    dc_run_nxt = (dc_run_r && !dcache_selftest_done) || d_dc;
    lab_rd_nxt = (lab_rd_r && !lab_rd_ack) || d_lr;
    seq_nxt = seq_r;
    dir_nxt = dir_r;
    cnt_nxt = cnt_r;
    for (int i = 0; i < 7; i++) begin
      shadow_nxt[i] = shadow_reg_array_r[i];
    end
    case (seq_r)
      diag_unit_pkg::st_idle: begin
        if (d_s2g || d_g2s) begin
          seq_nxt = diag_unit_pkg::st_copy;
          dir_nxt = d_g2s;
          cnt_nxt = 3'h0;
        end
      end
      diag_unit_pkg::st_copy: begin
        if (dir_r) shadow_nxt[cnt_r] = gpr_rd_data;
        if (cnt_r == `SHADOW_LAST) begin
          seq_nxt = diag_unit_pkg::st_wait;
        end else begin
          cnt_nxt = cnt_r + 3'h1;
        end
      end
      diag_unit_pkg::st_wait: seq_nxt = diag_unit_pkg::st_idle;
      default: seq_nxt = diag_unit_pkg::st_idle;
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      diag_bank_bit_r <= 1'b0;
      soft_trap_enable_flag_r <= 1'b0;
      toc_pend_r <= 1'b0;
      ic_run_r <= 1'b0;
      dc_run_r <= 1'b0;
      lab_rd_r <= 1'b0;
      seq_r <= diag_unit_pkg::st_idle;
      dir_r <= 1'b0;
      cnt_r <= 3'h0;
    end else if (clk_en) begin
      diag_bank_bit_r <= diag_bank_bit_nxt;
      soft_trap_enable_flag_r <= soft_trap_enable_flag_nxt;
      toc_pend_r <= toc_pend_nxt;
      ic_run_r <= ic_run_nxt;
      dc_run_r <= dc_run_nxt;
      lab_rd_r <= lab_rd_nxt;
      seq_r <= seq_nxt;
      dir_r <= dir_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  for (genvar g = 0; g < 7; g++) begin : g_shadow
    always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
        shadow_reg_array_r[g] <= 32'h0000_0000;
      end else if (clk_en) begin
        shadow_reg_array_r[g] <= shadow_nxt[g];
      end
    end
  end
  // the shadow copy relies on software having drained the pipe first
  assign insn_busy = (seq_r != diag_unit_pkg::st_idle) || lab_rd_r;
  assign gpr_rd_idx = (seq_r == diag_unit_pkg::st_copy) ? map_idx[cnt_r] : fld_x;
  assign sync_stall = sync_valid && (ic_run_r || dc_run_r);
  assign transfer_of_control_trap = toc_pend_r && soft_trap_enable_flag_r;
  ////////////////////////////////////////////////////////////////////////////
  // diagnose register banks
  logic [31:0] dr_rd;
  logic [31:0] vpn, rpn;
  logic [7:0] err_sync1_r, err_sync2_r;
  logic [7:0] err_sync1_nxt, err_sync2_nxt;
  // error lines come from other clock regions; only stage two is read
  always_comb begin
    err_sync1_nxt = machine_check_error_bits;
    err_sync2_nxt = err_sync1_r;
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      err_sync1_r <= 8'h00;
      err_sync2_r <= 8'h00;
    end else if (clk_en) begin
      err_sync1_r <= err_sync1_nxt;
      err_sync2_r <= err_sync2_nxt;
    end
  end
  logic wb_hit_errset;
  diag_reg_bank u_bank (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .wr_en(d_mt),
    .bank(diag_bank_bit_r),
    .wr_idx(fld_r),
    .wr_data(gpr_rd_data),
    .rd_idx(fld_r),
    .rd_data(dr_rd),
    .err_set(err_sync2_r | (wb_hit_errset ? wb_dat_i[7:0] : 8'h00)),
    .lab_load(lab_rd_r && lab_rd_ack),
    .lab_vpn(lab_rd_vpn),
    .lab_rpn(lab_rd_rpn),
    .vpn_out(vpn),
    .rpn_out(rpn)
  );
  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  diag_unit_pkg::gpr_wr_s gpr_wr_nxt;
  diag_unit_pkg::ret_state_s rest_nxt;
  logic priv_trap_nxt;
  logic illegal_insn_nxt;
  logic ic_start_nxt;
  logic dc_start_nxt;
  logic lab_wr_req_nxt;
  logic [31:0] lab_wr_vpn_nxt;
  logic [31:0] lab_wr_rpn_nxt;
  logic restore_valid_nxt;
  always_comb begin
    gpr_wr_nxt = '0;
    if ((d_mfa || d_mfb) && !mf_bad) begin
      gpr_wr_nxt.valid = 1'b1;
      gpr_wr_nxt.idx = d_mfa ? fld_t : fld_x;
      gpr_wr_nxt.data = dr_rd;
    end else if (seq_r == diag_unit_pkg::st_copy && !dir_r) begin
      gpr_wr_nxt.valid = 1'b1;
      gpr_wr_nxt.idx = map_idx[cnt_r];
      gpr_wr_nxt.data = shadow_reg_array_r[cnt_r];
    end
    // state is only taken over on a privileged return, else held
    rest_nxt = restored_state;
    if (d_ret) rest_nxt = saved_state;
    restore_valid_nxt = d_ret;
    priv_trap_nxt = is_diag && !privileged_ok;
    illegal_insn_nxt = (go && !any_known) || mf_bad;
    ic_start_nxt = d_ic;
    dc_start_nxt = d_dc;
    lab_wr_req_nxt = d_lw;
    lab_wr_vpn_nxt = lab_wr_vpn;
    lab_wr_rpn_nxt = lab_wr_rpn;
    if (d_lw) begin
      // page values held after the pulse so a slow buffer may latch late
      lab_wr_vpn_nxt = vpn;
      lab_wr_rpn_nxt = rpn;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      gpr_wr <= '0;
      priv_trap <= 1'b0;
      illegal_insn <= 1'b0;
      icache_selftest_start <= 1'b0;
      dcache_selftest_start <= 1'b0;
      lab_wr_req <= 1'b0;
      lab_wr_vpn <= 32'h0000_0000;
      lab_wr_rpn <= 32'h0000_0000;
      restored_state <= '0;
      restore_valid <= 1'b0;
    end else if (clk_en) begin
      gpr_wr <= gpr_wr_nxt;
      priv_trap <= priv_trap_nxt;
      illegal_insn <= illegal_insn_nxt;
      icache_selftest_start <= ic_start_nxt;
      dcache_selftest_start <= dc_start_nxt;
      lab_wr_req <= lab_wr_req_nxt;
      lab_wr_vpn <= lab_wr_vpn_nxt;
      lab_wr_rpn <= lab_wr_rpn_nxt;
      restored_state <= rest_nxt;
      restore_valid <= restore_valid_nxt;
    end
  end
  assign lab_rd_req = lab_rd_r;
  ////////////////////////////////////////////////////////////////////////////
  // wishbone status slave: ack one cycle after strobe
  logic ack_r;
  logic [31:0] rd_r, rd_nxt;
  logic req;
  assign req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wb_hit_errset = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == `WB_ADDR_ERRSET) && clk_en;
  always_comb begin
    case (wb_adr_i)
      `WB_ADDR_CTRL: rd_nxt = {29'h0, toc_pend_r, soft_trap_enable_flag_r, diag_bank_bit_r};
      `WB_ADDR_STATUS: rd_nxt = {28'h0, lab_rd_r, seq_r != diag_unit_pkg::st_idle, dc_run_r,
        ic_run_r};
      default: rd_nxt = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
      rd_r <= 32'h0000_0000;
    end else if (clk_en) begin
      ack_r <= req;
      rd_r <= req ? rd_nxt : rd_r;
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rd_r;
endmodule : diag_insn_unit

/* File: diag_insn_unit_asserts.sv */
// concurrent checks on the diagnose unit ports
`timescale 1ns/1ps
module diag_insn_checker (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire diag_unit_pkg::insn_s insn,
  input wire logic insn_busy,
  input wire logic sync_valid,
  input wire logic sync_stall,
  input wire logic priv_trap,
  input wire diag_unit_pkg::gpr_wr_s gpr_wr,
  input wire logic icache_selftest_start,
  input wire logic icache_selftest_done,
  input wire logic dcache_selftest_start,
  input wire logic lab_rd_req,
  input wire logic lab_wr_req,
  input wire logic transfer_of_control_trap
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic hit;
  logic go;
  logic [7:0] ext;
  assign hit = insn.valid && insn.word[31:26] == 6'h05 && !insn_busy;
  assign go = hit && insn.priv == 2'h0;
  assign ext = insn.word[12:5];
  sequence walk_s;
    gpr_wr.valid && gpr_wr.idx == 5'h01 ##1 gpr_wr.idx == 5'h08 ##1 gpr_wr.idx == 5'h09
    ##1 gpr_wr.idx == 5'h10 ##1 gpr_wr.idx == 5'h11 ##1 gpr_wr.idx == 5'h18
    ##1 gpr_wr.idx == 5'h19;
  endsequence
  sequence ic_run_s;
    icache_selftest_start ##1 (sync_valid && !icache_selftest_done);
  endsequence
  ////////////////////////////////////////
  AST_PRIV_TRAP: assert property (hit && insn.priv != 2'h0 |=> priv_trap)
    else $error("no trap at nonzero privilege");
  AST_IC_START: assert property (go && ext == 8'h40 |=> icache_selftest_start)
    else $error("icache test not started");
  AST_DC_START: assert property (go && ext == 8'h42 |=> dcache_selftest_start)
    else $error("dcache test not started");
  AST_SYNC_HOLD: assert property (ic_run_s |-> sync_stall)
    else $error("sync not stalled");
  AST_LAB_READ: assert property (go && ext == 8'hc0 |=> lab_rd_req)
    else $error("no lookaside read");
  AST_LAB_WRITE: assert property (go && ext == 8'hc2 |=> lab_wr_req)
    else $error("no lookaside write");
  AST_TRAP_MASK: assert property (go && ext == 8'h52 |=> !transfer_of_control_trap)
    else $error("trap not masked");
  AST_SHADOW_WALK: assert property (go && ext == 8'hd0 |=> ##1 walk_s)
    else $error("shadow copy order wrong");
endmodule : diag_insn_checker
bind diag_insn_unit diag_insn_checker u_chk (.ref_clk, .rst_b, .insn, .insn_busy,
  .sync_valid, .sync_stall, .priv_trap, .gpr_wr, .icache_selftest_start,
  .icache_selftest_done, .dcache_selftest_start, .lab_rd_req, .lab_wr_req,
  .transfer_of_control_trap);

/* File: diag_reg_bank.sv */
// two banks of diagnose registers with protected and write-one-clear bits
`timescale 1ns/1ps
`include "diag_unit_map.svh"
module diag_reg_bank (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic bank,
  input wire logic [4:0] wr_idx,
  input wire logic [31:0] wr_data,
  input wire logic [4:0] rd_idx,
  output logic [31:0] rd_data,
  input wire logic [7:0] err_set,
  input wire logic lab_load,
  input wire logic [31:0] lab_vpn,
  input wire logic [31:0] lab_rpn,
  output logic [31:0] vpn_out,
  output logic [31:0] rpn_out
);
  logic [31:0] regs_r [64];
  logic [31:0] regs_nxt [64];
  always_comb begin
    for (int i = 0; i < 64; i++) begin
      regs_nxt[i] = regs_r[i];
    end
    if (wr_en) begin
      if (wr_idx == `DR_ERR_REG) begin
        // error bits clear on one, rest keep ro bits
        regs_nxt[{bank, wr_idx}] = (regs_r[{bank, wr_idx}] & `DR_RO_MASK)
          | (wr_data & ~`DR_RO_MASK & ~`DR_ERR_MASK)
          | (regs_r[{bank, wr_idx}] & `DR_ERR_MASK & ~wr_data);
      end else begin
        regs_nxt[{bank, wr_idx}] = (regs_r[{bank, wr_idx}] & `DR_RO_MASK)
          | (wr_data & ~`DR_RO_MASK);
      end
    end
    // hardware set wins over a same-cycle clear
    regs_nxt[0][7:0] = regs_nxt[0][7:0] | err_set;
    if (lab_load) begin
      regs_nxt[{1'b0, `DR_LAB_VPN}] = lab_vpn;
      regs_nxt[{1'b0, `DR_LAB_RPN}] = lab_rpn;
    end
  end
  for (genvar g = 0; g < 64; g++) begin : g_reg
    always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
        regs_r[g] <= 32'h0000_0000;
      end else if (clk_en) begin
        regs_r[g] <= regs_nxt[g];
      end
    end
  end
  assign rd_data = regs_r[{bank, rd_idx}] & ~`DR_WO_MASK;
  assign vpn_out = regs_r[{1'b0, `DR_LAB_VPN}];
  assign rpn_out = regs_r[{1'b0, `DR_LAB_RPN}];
endmodule : diag_reg_bank

/* File: diag_unit_map.svh */
// offsets, field positions, reset values and codes for the diagnose unit
`ifndef DIAG_UNIT_MAP_SVH
`define DIAG_UNIT_MAP_SVH
`define DIAG_MAJOR_OP 6'h05
`define DIAG_EXT_MASK 8'hf2
`define EXT_MOVE_TO 8'h12
`define EXT_MOVE_FROM_A 8'ha0
`define EXT_MOVE_FROM_B 8'h30
`define EXT_ICACHE_TEST 8'h40
`define EXT_DCACHE_TEST 8'h42
`define EXT_LAB_READ 8'hc0
`define EXT_LAB_WRITE 8'hc2
`define EXT_TRAP_UNMASK 8'h50
`define EXT_TRAP_MASK 8'h52
`define EXT_SHADOW_TO_GPR 8'hd0
`define EXT_GPR_TO_SHADOW 8'hd2
`define EXT_IMPL_RETURN 8'h60
`define EXT_IMPL_RET_MASK 8'hf8
`define EXT_BANK_ZERO 8'h70
`define EXT_BANK_ONE 8'h72
`define DR_ERR_REG 5'h00
`define DR_CH_REG 5'h08
`define DR_LAB_VPN 5'h10
`define DR_LAB_RPN 5'h11
`define SHADOW_LAST 3'h6
`define DR_ERR_MASK 32'h0000_00ff
`define DR_RO_MASK 32'hff00_0000
`define DR_WO_MASK 32'h00ff_0000
`define WB_ADDR_CTRL 4'h0
`define WB_ADDR_STATUS 4'h4
`define WB_ADDR_ERRSET 4'h8
`define CTRL_RESET 32'h0000_0000
`endif

/* File: diag_unit_pkg.sv */
// types shared by the diagnose unit
package diag_unit_pkg;
  typedef struct packed {
    logic valid;
    logic [31:0] word;
    logic [1:0] priv;
    logic [31:0] gpr_x;
  } insn_s;
  typedef struct packed {
    logic valid;
    logic [4:0] idx;
    logic [31:0] data;
  } gpr_wr_s;
  typedef struct packed {
    logic [31:0] status;
    logic [31:0] off_front;
    logic [31:0] off_back;
    logic [31:0] spc_front;
    logic [31:0] spc_back;
  } ret_state_s;
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_copy = 3'b010,
    st_wait = 3'b100
  } seq_e;
endpackage : diag_unit_pkg

/* File: diagnose_instruction_unit_tb.sv */
// self-checking bench for the diagnose instruction unit
`timescale 1ns/1ps
`include "diag_unit_map.svh"
module diagnose_instruction_unit_tb;
  localparam logic [31:0] hid_mask = `DR_RO_MASK | `DR_WO_MASK;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic sync_valid = 1'b0;
  logic toc_request = 1'b0;
  logic slow = 1'b0;
  logic [7:0] mc_err = 8'h00;
  logic wb_we = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic [3:0] wb_adr = 4'h0;
  logic [31:0] wb_dat = 32'h0;
  diag_unit_pkg::insn_s insn = '0;
  diag_unit_pkg::gpr_wr_s gpr_wr;
  diag_unit_pkg::ret_state_s saved_state, restored_state;
  logic insn_busy, sync_stall, priv_trap, illegal_insn, icache_selftest_start;
  logic icache_selftest_done, dcache_selftest_start, dcache_selftest_done, lab_rd_req;
  logic lab_rd_ack, lab_wr_req, transfer_of_control_trap, restore_valid, wb_ack;
  logic [4:0] gpr_rd_idx;
  logic [31:0] gpr_rd_data, lab_rd_vpn, lab_rd_rpn, lab_wr_vpn, lab_wr_rpn, wb_q, wb_dat_o;
  int mismatches = 0;
  int samples_checked = 0;
  always #20 ref_clk = ~ref_clk;
  diag_insn_unit u_dut (.ref_clk, .rst_b, .clk_en(1'b1), .insn, .insn_busy, .sync_valid,
    .sync_stall, .priv_trap, .illegal_insn, .gpr_wr, .gpr_rd_idx, .gpr_rd_data,
    .icache_selftest_start, .icache_selftest_done, .dcache_selftest_start,
    .dcache_selftest_done, .lab_rd_req, .lab_rd_ack, .lab_rd_vpn, .lab_rd_rpn, .lab_wr_req,
    .lab_wr_vpn, .lab_wr_rpn, .toc_request, .transfer_of_control_trap, .saved_state,
    .restored_state, .restore_valid, .machine_check_error_bits(mc_err), .wb_adr_i(wb_adr),
    .wb_dat_i(wb_dat), .wb_dat_o, .wb_we_i(wb_we), .wb_sel_i(4'hf), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_ack_o(wb_ack));
  diag_far_model u_far (.ref_clk, .rst_b, .slow, .gpr_rd_idx, .gpr_rd_data,
    .icache_selftest_start, .icache_selftest_done, .dcache_selftest_start,
    .dcache_selftest_done, .lab_rd_req, .lab_rd_ack, .lab_rd_vpn, .lab_rd_rpn, .saved_state);
  ////////////////////////////////////////
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up
  function automatic logic [31:0] iw(input logic [7:0] e, input logic [4:0] r, x, t);
    return {6'h05, r, x, 3'h0, e, t};
  endfunction : iw
  task automatic cwr(input logic [4:0] i, input logic [31:0] d);
    chk(40'({gpr_wr.valid, gpr_wr.idx, gpr_wr.data}), 40'({1'b1, i, d}));
  endtask : cwr
  // ends at the falling edge after the taking edge, where answers stand
  task automatic issue(input logic [31:0] w, input logic [1:0] p);
    int n;
    n = 0;
    @(posedge ref_clk);
    insn <= '{1'b1, w, p, 32'h0};
    do @(posedge ref_clk); while (insn_busy !== 1'b0 && ++n < 40);
    insn <= '0;
    @(negedge ref_clk);
  endtask : issue
  task automatic wb(input logic [3:0] a, input logic we, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    wb_adr <= a;
    wb_we <= we;
    wb_dat <= d;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    do @(posedge ref_clk); while (wb_ack !== 1'b1 && ++n < 40);
    wb_q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb
  ////////////////////////////////////////
  task automatic t_bank;
    issue(iw(8'h12, 5'h05, 5'h03, 5'h0), 2'h0);
    issue(iw(8'h72, 5'h0, 5'h0, 5'h0), 2'h0);
    wb(4'h0, 1'b0, 32'h0);
    chk(wb_q[0], 1'b1);
    issue(iw(8'h12, 5'h05, 5'h07, 5'h0), 2'h0);
    issue(iw(8'ha0, 5'h05, 5'h0, 5'h02), 2'h0);
    cwr(5'h02, {24'ha53c96, 8'h07} & ~hid_mask);
    issue(iw(8'h7d, 5'h0, 5'h0, 5'h0), 2'h0);
    issue(iw(8'ha0, 5'h05, 5'h0, 5'h02), 2'h0);
    cwr(5'h02, {24'ha53c96, 8'h03} & ~hid_mask);
    issue(32'h1800_0e40, 2'h0);
    issue(iw(8'h72, 5'h0, 5'h0, 5'h0), 2'h2);
    chk(priv_trap, 1'b1);
    wb(4'h0, 1'b0, 32'h0);
    chk(wb_q[0], 1'b0);
    wb(4'hc, 1'b1, 32'hffff_ffff);
    wb(4'hc, 1'b0, 32'h0);
    chk(wb_q, 32'h0);
  endtask : t_bank
  task automatic t_err;
    wb(4'h8, 1'b1, 32'h0000_00ff);
    issue(iw(8'h30, 5'h0, 5'h04, 5'h0), 2'h0);
    cwr(5'h04, 32'h0000_00ff);
    issue(iw(8'h12, 5'h0, 5'h05, 5'h0), 2'h0);
    issue(iw(8'h30, 5'h0, 5'h04, 5'h0), 2'h0);
    cwr(5'h04, 32'h0000_96fa);
    issue(iw(8'ha0, 5'h08, 5'h0, 5'h02), 2'h0);
    chk({illegal_insn, gpr_wr.valid}, 2'b10);
    @(posedge ref_clk);
    mc_err <= 8'h05;
    repeat (3) @(posedge ref_clk);
    mc_err <= 8'h00;
    issue(iw(8'h30, 5'h0, 5'h04, 5'h0), 2'h0);
    cwr(5'h04, 32'h0000_96ff);
  endtask : t_err
  task automatic t_test(input logic [7:0] e, input logic s);
    int n;
    n = 0;
    @(posedge ref_clk);
    slow <= s;
    sync_valid <= 1'b1;
    issue(iw(e, 5'h0, 5'h0, 5'h0), 2'h0);
    chk({icache_selftest_start, dcache_selftest_start}, {e == 8'h40, e == 8'h42});
    chk(sync_stall, 1'b1);
    while (sync_stall === 1'b1 && n < 60) begin
      @(negedge ref_clk);
      n++;
    end
    chk(n > (s ? 27 : 2) && n < (s ? 35 : 9), 1'b1);
    @(posedge ref_clk);
    sync_valid <= 1'b0;
  endtask : t_test
  task automatic t_lab;
    issue(iw(8'hc0, 5'h0, 5'h0, 5'h0), 2'h0);
    chk(lab_rd_req, 1'b1);
    issue(iw(8'ha0, 5'h10, 5'h0, 5'h06), 2'h0);
    cwr(5'h06, 32'h1234);
    issue(iw(8'ha0, 5'h11, 5'h0, 5'h07), 2'h0);
    cwr(5'h07, 32'h5678);
    issue(iw(8'hc2, 5'h0, 5'h0, 5'h0), 2'h0);
    chk({lab_wr_req, lab_wr_vpn}, {1'b1, 32'h1234});
    chk(lab_wr_rpn, 32'h5678);
  endtask : t_lab
  task automatic t_trap;
    issue(iw(8'h52, 5'h0, 5'h0, 5'h0), 2'h0);
    @(posedge ref_clk);
    toc_request <= 1'b1;
    @(posedge ref_clk);
    toc_request <= 1'b0;
    @(negedge ref_clk);
    chk(transfer_of_control_trap, 1'b0);
    wb(4'h0, 1'b0, 32'h0);
    chk(wb_q[2:1], 2'b10);
    issue(iw(8'h50, 5'h0, 5'h0, 5'h0), 2'h0);
    chk(transfer_of_control_trap, 1'b1);
    issue(iw(8'h52, 5'h0, 5'h0, 5'h0), 2'h0);
    chk(transfer_of_control_trap, 1'b0);
  endtask : t_trap
  task automatic t_shadow;
    logic [4:0] map [7] = '{5'h01, 5'h08, 5'h09, 5'h10, 5'h11, 5'h18, 5'h19};
    for (int j = 0; j < 2; j++) begin
      repeat (2) begin
        @(posedge ref_clk);
        sync_valid <= 1'b1;
        @(posedge ref_clk);
        sync_valid <= 1'b0;
      end
      issue(iw(j ? 8'hd0 : 8'hd2, 5'h0, 5'h0, 5'h0), 2'h0);
    end
    // first copied word shows one cycle after the taking edge
    for (int k = 0; k < 7; k++) begin
      @(negedge ref_clk);
      cwr(map[k], {24'ha53c96, 3'h0, map[k]});
    end
  endtask : t_shadow
  task automatic t_ret;
    issue(iw(8'h60, 5'h0, 5'h0, 5'h0), 2'h1);
    chk({priv_trap, restore_valid}, 2'b10);
    issue(iw(8'h60, 5'h0, 5'h0, 5'h0), 2'h0);
    chk({restore_valid, restored_state === saved_state}, 2'b11);
  endtask : t_ret
  ////////////////////////////////////////
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_bank;
    t_err;
    t_test(8'h40, 1'b0);
    t_test(8'h42, 1'b1);
    t_lab;
    t_trap;
    t_shadow;
    t_ret;
    wrap_up;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    wrap_up;
  end
endmodule : diagnose_instruction_unit_tb
